// File: hdl/eep_pkg.sv
// Shared constants for the serial nonvolatile memory link
package eep_pkg;
    localparam int WORD_W = 16;
    localparam int WORD_CNT = 16;
    localparam int OP_W = 4;
    localparam int ADDR_W = 4;
    localparam int CMD_W = OP_W + ADDR_W;
    localparam int FRAME_BITS = 1 + CMD_W;
    localparam int READ_BITS = 1 + WORD_W;
    localparam int RISES_PLAIN = FRAME_BITS;
    localparam int RISES_DATA = FRAME_BITS + WORD_W;
    localparam int RISES_READ = FRAME_BITS + READ_BITS;
    // Opcode classes (upper two opcode bits) and full special codes
    localparam logic [1:0] CLS_SPECIAL = 2'h0;
    localparam logic [1:0] CLS_WRITE = 2'h1;
    localparam logic [1:0] CLS_READ = 2'h2;
    localparam logic [1:0] CLS_ERASE = 2'h3;
    localparam logic [3:0] OP_LOCK = 4'h0;
    localparam logic [3:0] OP_BULK_WRITE = 4'h1;
    localparam logic [3:0] OP_BULK_ERASE = 4'h2;
    localparam logic [3:0] OP_UNLOCK = 4'h3;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int PROG_TIME_NS = 10000000;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int SK_PERIOD_NS = 1000;
    localparam int SK_HALF_CYCLES = (SK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_LOW_NS = 250;
    localparam int CS_LOW_CYCLES = (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATUS_VALID_NS = 500;
    localparam int STATUS_CYCLES = (STATUS_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// File: hdl/eep_link_if.sv
// Four-wire serial link between host and memory device
`timescale 1ns/1ps
interface eep_link_if;
    logic chip_sel;
    logic serial_clock;
    logic serial_in;
    logic data_out;
    logic data_out_en;
    logic line_level;

    // Pulled high while nobody drives
    assign line_level = data_out_en ? data_out : 1'b1;

    modport device (
        input chip_sel,
        input serial_clock,
        input serial_in,
        output data_out,
        output data_out_en
    );
    modport host (
        output chip_sel,
        output serial_clock,
        output serial_in,
        input line_level
    );
endinterface

// File: hdl/eep_device.sv
// Memory device end of the serial link
// Summary of operation
// - Sixteen words of sixteen bits, bit-serial access
// - Frame: start one, opcode, then address
// - Opcode 10XX reads the addressed word
// - Opcode 01XX writes sixteen bits, MSB first
// - Opcode 11XX erases word, no data
// - 0011 unlocks programming, 0000 locks it
// - 0010 erases all, 0001 writes all
// - Read: dummy zero then sixteen bits out
// - Lock set at reset, kept until changed
// - Host unlocks before any programming command
// - Reads work whatever the lock state
// - Chip select fall starts programming cycle
// - Host drops select right after data
// - Bulk erase sets every bit to one
// - Host erases array before bulk write
// - Bulk write fills all words at once
// - Select high shows busy zero, ready one
// - Output undriven except read and status
// - Programming completes within ten milliseconds
// - Host keeps select low 250 ns
// - Serial clock period at least 1 us
`timescale 1ns/1ps
module eep_device #(
    parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Link
    eep_link_if.device link,
    // Status
    output logic busy_out,
    output logic unlocked_out
);
    localparam int CW = $clog2(PROG_CYCLES + 1);

    typedef enum logic [7:0] {
        D_IDLE = 8'h01,
        D_CMD = 8'h02,
        D_DATA = 8'h04,
        D_READ = 8'h08,
        D_ARMED = 8'h10,
        D_HOLD = 8'h20,
        D_STATUS = 8'h40,
        D_SHOW = 8'h80
    } eep_dev_st_t;

    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] sk_s;
        logic [2:0] di_s;
        logic cs_f;
        logic sk_f;
        logic di_f;
        logic sk_prev;
        eep_dev_st_t st;
        logic [4:0] cnt;
        logic [7:0] cmd;
        logic [15:0] data;
        logic [16:0] rd_sh;
        logic unlock;
        logic busy;
        logic [CW-1:0] prog_cnt;
        logic [3:0] p_op;
        logic [3:0] p_addr;
        logic [15:0] p_data;
        logic [15:0][15:0] mem;
        logic dout;
        logic dout_en;
    } eep_dev_state_t;

    localparam eep_dev_state_t RST_STATE = '{st: D_IDLE, mem: '1, default: '0};

    eep_dev_state_t r_reg;
    eep_dev_state_t r_next;

    always_comb begin
        logic rise;
        logic [7:0] c;
        rise = 1'b0;
        c = '0;
        r_next = r_reg;
        // Three-stage input synchronisers with agreement filter
        r_next.cs_s = {r_reg.cs_s[1:0], link.chip_sel};
        r_next.sk_s = {r_reg.sk_s[1:0], link.serial_clock};
        r_next.di_s = {r_reg.di_s[1:0], link.serial_in};
        if (r_reg.cs_s[1] == r_reg.cs_s[2]) begin
            r_next.cs_f = r_reg.cs_s[2];
        end
        if (r_reg.sk_s[1] == r_reg.sk_s[2]) begin
            r_next.sk_f = r_reg.sk_s[2];
        end
        if (r_reg.di_s[1] == r_reg.di_s[2]) begin
            r_next.di_f = r_reg.di_s[2];
        end
        r_next.sk_prev = r_reg.sk_f;
        rise = r_reg.sk_f & ~r_reg.sk_prev;
        c = {r_reg.cmd[6:0], r_reg.di_f};

        // Self-timed programming cycle
        if (r_reg.busy) begin
            r_next.prog_cnt = r_reg.prog_cnt - 1'b1;
            if (r_reg.prog_cnt == CW'(1)) begin
                r_next.busy = 1'b0;
                if (r_reg.p_op == eep_pkg::OP_BULK_ERASE) begin
                    for (int i = 0; i < eep_pkg::WORD_CNT; i++) begin
                        r_next.mem[i] = eep_pkg::ERASED_WORD;
                    end
                end else if (r_reg.p_op == eep_pkg::OP_BULK_WRITE) begin
                    for (int i = 0; i < eep_pkg::WORD_CNT; i++) begin
                        r_next.mem[i] = r_reg.p_data;
                    end
                end else if (r_reg.p_op[3:2] == eep_pkg::CLS_ERASE) begin
                    r_next.mem[r_reg.p_addr] = eep_pkg::ERASED_WORD;
                end else begin
                    r_next.mem[r_reg.p_addr] = r_reg.p_data;
                end
            end
        end

        // Frame sequencing
        if (!r_reg.cs_f) begin
            case (r_reg.st)
                D_ARMED: begin
                    if (r_reg.unlock && !r_reg.busy) begin
                        // Select fall launches the cycle
                        r_next.busy = 1'b1;
                        r_next.prog_cnt = CW'(PROG_CYCLES);
                        r_next.p_op = r_reg.cmd[7:4];
                        r_next.p_addr = r_reg.cmd[3:0];
                        r_next.p_data = r_reg.data;
                        r_next.st = D_STATUS;
                    end else begin
                        r_next.st = D_IDLE;
                    end
                end
                D_STATUS: begin
                    r_next.st = D_STATUS;
                end
                D_SHOW: begin
                    r_next.st = r_reg.busy ? D_STATUS : D_IDLE;
                end
                default: begin
                    r_next.st = D_IDLE;
                end
            endcase
        end else begin
            case (r_reg.st)
                D_IDLE: begin
                    if (rise && r_reg.di_f && !r_reg.busy) begin
                        r_next.st = D_CMD;
                        r_next.cnt = '0;
                    end
                end
                D_CMD: begin
                    if (rise) begin
                        r_next.cmd = c;
                        r_next.cnt = r_reg.cnt + 5'h01;
                        if (r_reg.cnt == 5'h07) begin
                            r_next.cnt = '0;
                            case (c[7:6])
                                eep_pkg::CLS_READ: begin
                                    r_next.st = D_READ;
                                    r_next.rd_sh = {1'b0, r_reg.mem[c[3:0]]};
                                end
                                eep_pkg::CLS_WRITE: begin
                                    r_next.st = D_DATA;
                                end
                                eep_pkg::CLS_ERASE: begin
                                    r_next.st = D_ARMED;
                                end
                                default: begin
                                    r_next.st = D_HOLD;
                                    if (c[7:4] == eep_pkg::OP_UNLOCK) begin
                                        r_next.unlock = 1'b1;
                                    end else if (c[7:4] == eep_pkg::OP_LOCK) begin
                                        r_next.unlock = 1'b0;
                                    end else if (c[7:4] == eep_pkg::OP_BULK_ERASE) begin
                                        r_next.st = D_ARMED;
                                    end else begin
                                        r_next.st = D_DATA;
                                    end
                                end
                            endcase
                        end
                    end
                end
                D_DATA: begin
                    if (rise) begin
                        r_next.data = {r_reg.data[14:0], r_reg.di_f};
                        r_next.cnt = r_reg.cnt + 5'h01;
                        if (r_reg.cnt == 5'h0f) begin
                            r_next.st = D_ARMED;
                        end
                    end
                end
                D_READ: begin
                    if (rise) begin
                        r_next.dout = r_reg.rd_sh[16];
                        r_next.rd_sh = {r_reg.rd_sh[15:0], 1'b0};
                        if (r_reg.cnt != 5'h1f) begin
                            r_next.cnt = r_reg.cnt + 5'h01;
                        end
                    end
                end
                D_ARMED: begin
                    // Extra clock before select fall cancels the command
                    if (rise) begin
                        r_next.st = D_HOLD;
                    end
                end
                D_STATUS: begin
                    r_next.st = D_SHOW;
                end
                default: begin
                    r_next.st = r_reg.st;
                end
            endcase
        end

        // Output drive
        r_next.dout_en = r_next.cs_f && ((r_next.st == D_READ && r_next.cnt != '0)
            || r_next.st == D_SHOW);
        if (r_next.st == D_SHOW) begin
            r_next.dout = ~r_next.busy;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            r_reg <= RST_STATE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.data_out = r_reg.dout;
    assign link.data_out_en = r_reg.dout_en;
    assign busy_out = r_reg.busy;
    assign unlocked_out = r_reg.unlock;
endmodule

// File: hdl/eep_host.sv
// Host end of the serial link: issues one command at a time
`timescale 1ns/1ps
module eep_host #(
    parameter int HALF_CYCLES = eep_pkg::SK_HALF_CYCLES,
    parameter int CS_LOW_CYCLES = eep_pkg::CS_LOW_CYCLES,
    parameter int STATUS_CYCLES = eep_pkg::STATUS_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Command request
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic [3:0] cmd_op_in,
    input wire logic [3:0] cmd_addr_in,
    input wire logic [15:0] cmd_data_in,
    // Answer
    output logic [15:0] rd_data_out,
    output logic rd_valid_out,
    output logic done_out,
    // Link
    eep_link_if.host link
);
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_SHIFT = 4'h2,
        H_GAP = 4'h4,
        H_POLL = 4'h8
    } eep_host_st_t;

    typedef struct packed {
        logic [2:0] do_s;
        logic do_f;
        eep_host_st_t st;
        logic [5:0] div;
        logic [5:0] wait_cnt;
        logic sk;
        logic cs;
        logic di;
        logic [24:0] sh;
        logic [4:0] nbits;
        logic [4:0] cnt;
        logic [15:0] rd;
        logic is_read;
        logic is_prog;
        logic rd_valid;
        logic done;
    } eep_host_state_t;

    localparam eep_host_state_t RST_STATE = '{st: H_IDLE, default: '0};

    eep_host_state_t r_reg;
    eep_host_state_t r_next;

    always_comb begin
        logic has_data;
        has_data = 1'b0;
        r_next = r_reg;
        r_next.rd_valid = 1'b0;
        r_next.done = 1'b0;
        r_next.do_s = {r_reg.do_s[1:0], link.line_level};
        if (r_reg.do_s[1] == r_reg.do_s[2]) begin
            r_next.do_f = r_reg.do_s[2];
        end
        case (r_reg.st)
            H_IDLE: begin
                // Caller sends unlock before programming and erases before bulk write
                if (cmd_valid_in) begin
                    has_data = cmd_op_in[3:2] == eep_pkg::CLS_WRITE || cmd_op_in == eep_pkg::OP_BULK_WRITE;
                    r_next.is_read = cmd_op_in[3:2] == eep_pkg::CLS_READ;
                    r_next.is_prog = has_data || cmd_op_in[3:2] == eep_pkg::CLS_ERASE
                        || cmd_op_in == eep_pkg::OP_BULK_ERASE;
                    r_next.nbits = r_next.is_read ? 5'(eep_pkg::RISES_READ)
                        : has_data ? 5'(eep_pkg::RISES_DATA) : 5'(eep_pkg::RISES_PLAIN);
                    r_next.sh = {1'b1, cmd_op_in, cmd_addr_in, cmd_data_in};
                    r_next.di = 1'b1;
                    r_next.cs = 1'b1;
                    r_next.sk = 1'b0;
                    r_next.cnt = '0;
                    r_next.div = '0;
                    r_next.st = H_SHIFT;
                end
            end
            H_SHIFT: begin
                r_next.div = r_reg.div + 6'h01;
                if (r_reg.div == 6'(HALF_CYCLES - 1)) begin
                    r_next.div = '0;
                    if (!r_reg.sk) begin
                        r_next.sk = 1'b1;
                    end else begin
                        r_next.sk = 1'b0;
                        r_next.cnt = r_reg.cnt + 5'h01;
                        r_next.sh = {r_reg.sh[23:0], 1'b0};
                        r_next.di = r_reg.sh[23];
                        if (r_reg.is_read && r_reg.cnt >= 5'(eep_pkg::FRAME_BITS)) begin
                            r_next.rd = {r_reg.rd[14:0], r_reg.do_f};
                        end
                        if (r_reg.cnt + 5'h01 == r_reg.nbits) begin
                            r_next.cs = 1'b0;
                            r_next.di = 1'b0;
                            r_next.wait_cnt = '0;
                            r_next.st = H_GAP;
                            r_next.rd_valid = r_reg.is_read;
                            r_next.done = ~r_reg.is_prog;
                        end
                    end
                end
            end
            H_GAP: begin
                r_next.wait_cnt = r_reg.wait_cnt + 6'h01;
                if (r_reg.wait_cnt == 6'(CS_LOW_CYCLES - 1)) begin
                    r_next.wait_cnt = '0;
                    if (r_reg.is_prog) begin
                        r_next.cs = 1'b1;
                        r_next.st = H_POLL;
                    end else begin
                        r_next.st = H_IDLE;
                    end
                end
            end
            H_POLL: begin
                if (r_reg.wait_cnt != 6'(STATUS_CYCLES)) begin
                    r_next.wait_cnt = r_reg.wait_cnt + 6'h01;
                end else if (r_reg.do_f) begin
                    r_next.cs = 1'b0;
                    r_next.is_prog = 1'b0;
                    r_next.done = 1'b1;
                    r_next.wait_cnt = '0;
                    r_next.st = H_GAP;
                end
            end
            default: begin
                r_next.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            r_reg <= RST_STATE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign cmd_ready_out = r_reg.st == H_IDLE;
    assign rd_data_out = r_reg.rd;
    assign rd_valid_out = r_reg.rd_valid;
    assign done_out = r_reg.done;
    assign link.chip_sel = r_reg.cs;
    assign link.serial_clock = r_reg.sk;
    assign link.serial_in = r_reg.di;
endmodule

// File: dv/eep_link_sva.sv
// Assertions on the serial link between host and device
`timescale 1ns/1ps
module eep_link_sva (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Link wires
    input wire logic chip_sel,
    input wire logic serial_clock,
    input wire logic serial_in,
    input wire logic data_out,
    input wire logic data_out_en,
    input wire logic line_level,
    // Device status
    input wire logic busy_out,
    input wire logic unlocked_out
);
    localparam int READY_MAX = 260;
    logic sk_d_reg;
    logic [4:0] rises_reg;
    logic [3:0] op_reg;
    logic [7:0] gap_reg;
    logic rise;
    assign rise = serial_clock & ~sk_d_reg;
    // Rise counter per frame, opcode capture, spacing of rises
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sk_d_reg <= 1'b0;
            rises_reg <= 5'h00;
            op_reg <= 4'h0;
            gap_reg <= 8'hff;
        end else begin
            sk_d_reg <= serial_clock;
            gap_reg <= rise ? 8'h00 : ((gap_reg == 8'hff) ? 8'hff : gap_reg + 8'h01);
            if (!chip_sel) begin
                rises_reg <= 5'h00;
            end else if (rise && rises_reg != 5'h1f) begin
                rises_reg <= rises_reg + 5'h01;
            end
            if (rise && chip_sel && rises_reg >= 5'h01 && rises_reg <= 5'h04) begin
                op_reg <= {op_reg[2:0], serial_in};
            end
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_read_addr;
        rise && chip_sel && rises_reg == 5'h09 && op_reg[3:2] == eep_pkg::CLS_READ;
    endsequence
    sequence s_show_busy;
        ##[1:40] (data_out_en && !data_out);
    endsequence
    sequence s_show_ready;
        ##[1:READY_MAX] (data_out_en && data_out);
    endsequence
    chk_start_bit: assert property (rise && chip_sel && rises_reg == 5'h00 |-> serial_in)
        else $error("frame does not open with a one");
    chk_clock_period: assert property (rise |-> gap_reg >= 8'h18)
        else $error("serial clock period too short");
    chk_select_gap: assert property ($fell(chip_sel) |-> !chip_sel [*7])
        else $error("select low time too short");
    chk_data_len: assert property (rise && chip_sel && (op_reg[3:2] == 2'h1 || op_reg == 4'h1) |-> rises_reg < 5'h19)
        else $error("rise after final write bit");
    chk_plain_len: assert property (rise && chip_sel && (op_reg[3:2] == 2'h3 || op_reg inside {4'h0, 4'h2, 4'h3})
        |-> rises_reg < 5'h09)
        else $error("rise after plain frame");
    chk_read_dummy: assert property (s_read_addr |-> ##[1:8] (data_out_en && !data_out))
        else $error("dummy zero missing");
    chk_line_idle: assert property (!chip_sel [*8] |-> !data_out_en && line_level)
        else $error("output driven while deselected");
    chk_busy_status: assert property ($rose(busy_out) |-> s_show_busy)
        else $error("busy status not shown");
    chk_ready_bound: assert property ($rose(busy_out) |-> s_show_ready)
        else $error("ready status late");
    chk_lock_reset: assert property ($rose(rst_n_in) |-> !unlocked_out)
        else $error("latch set after reset");
    chk_locked_idle: assert property ($rose(busy_out) |-> unlocked_out)
        else $error("programming while locked");
endmodule

// File: dv/serial_eeprom_16x16_selftimed_test.sv
// Bench for the serial memory link: host and device face to face
`timescale 1ns/1ps
module serial_eeprom_16x16_selftimed_test;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cmd_valid = 1'b0;
    logic [3:0] cmd_op = 4'h0;
    logic [3:0] cmd_addr = 4'h0;
    logic [15:0] cmd_data = 16'h0000;
    logic cmd_ready, rd_valid, done, busy, unlocked;
    logic [15:0] rd_data;
    logic [15:0] got;
    logic [3:0] a;
    logic [15:0] d;
    int err_count = 0;
    int comparisons = 0;
    int mem [16];
    bit lock_open = 0;
    logic [3:0] lk_ops [4] = '{4'h4, 4'h2, 4'h1, 4'hc};
    eep_link_if link ();
    always #20 clk_in = ~clk_in;
    eep_device #(.PROG_CYCLES(200)) i_eep_device (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
        .busy_out(busy), .unlocked_out(unlocked));
    eep_host i_eep_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
        .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .done_out(done), .link(link));
    eep_link_sva i_eep_link_sva (.clk_in(clk_in), .rst_n_in(rst_n_in), .chip_sel(link.chip_sel),
        .serial_clock(link.serial_clock), .serial_in(link.serial_in), .data_out(link.data_out),
        .data_out_en(link.data_out_en), .line_level(link.line_level), .busy_out(busy), .unlocked_out(unlocked));
    task automatic fail(input string msg);
        err_count++;
        $display("ERROR at %0t: %s", $time, msg);
    endtask
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) fail($sformatf("word %h expected %h", g, e));
    endtask
    task automatic chk_flag(input logic g, input logic e);
        comparisons++;
        if (g !== e) fail($sformatf("latch %b expected %b", g, e));
    endtask
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One command: wait ready, offer, wait completion
    task automatic do_cmd(input logic [3:0] op, input logic [3:0] ad, input logic [15:0] dt);
        int n;
        n = 0;
        got = 'x;
        @(posedge clk_in);
        #1;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (n >= 100) fail("host never ready");
        @(posedge clk_in);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= ad;
        cmd_data <= dt;
        @(posedge clk_in);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
            if (rd_valid === 1'b1) got = rd_data;
        end while (done !== 1'b1 && n < 3000);
        if (n >= 3000) fail("command never completed");
    endtask
    task automatic rd(input logic [3:0] ad);
        do_cmd({2'h2, 2'($urandom)}, ad, 16'($urandom));
    endtask
    // Command plus model update
    task automatic prog(input logic [3:0] op, input logic [3:0] ad, input logic [15:0] dt);
        do_cmd(op, ad, dt);
        if (op == 4'h3) lock_open = 1;
        else if (op == 4'h0) lock_open = 0;
        else if (lock_open) begin
            for (int i = 0; i < 16; i++) begin
                if ((op[3:2] == 2'h1 && i == ad) || op == 4'h1) mem[i] = dt;
                if ((op[3:2] == 2'h3 && i == ad) || op == 4'h2) mem[i] = 16'hffff;
            end
        end
    endtask
    initial begin
        void'($urandom(70289));
        for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        #1;
        chk_flag(unlocked, 1'b0);
        for (int i = 0; i < 16; i++) begin
            rd(4'(i));
            chk_word(got, 16'(mem[i]));
        end
        $display("test reset done");
        foreach (lk_ops[k]) begin
            a = 4'($urandom);
            prog(lk_ops[k] | ({2'h0, 2'($urandom)} & {4{k == 0 || k == 3}}), a, 16'($urandom));
            rd(a);
            chk_word(got, 16'(mem[a]));
        end
        $display("test locked done");
        prog(4'h3, 4'($urandom), 16'h0000);
        chk_flag(unlocked, 1'b1);
        for (int k = 0; k < 4; k++) begin
            a = 4'($urandom);
            prog({2'h1, 2'($urandom)}, a, 16'($urandom));
            rd(a);
            chk_word(got, 16'(mem[a]));
        end
        $display("test write done");
        prog({2'h3, 2'($urandom)}, a, 16'h0000);
        rd(a);
        chk_word(got, 16'(mem[a]));
        rd(a + 4'h1);
        chk_word(got, 16'(mem[a + 4'h1]));
        $display("test erase done");
        prog(4'h2, 4'($urandom), 16'h0000);
        rd(a);
        chk_word(got, 16'(mem[a]));
        d = 16'($urandom);
        prog(4'h1, 4'($urandom), d);
        for (int k = 0; k < 3; k++) begin
            a = 4'($urandom);
            rd(a);
            chk_word(got, 16'(mem[a]));
        end
        $display("test bulk done");
        prog(4'h0, 4'($urandom), 16'h0000);
        chk_flag(unlocked, 1'b0);
        prog({2'h1, 2'($urandom)}, a, ~d);
        rd(a);
        chk_word(got, 16'(mem[a]));
        $display("test relock done");
        conclude();
    end
    initial begin
        repeat (60000) @(posedge clk_in);
        fail("watchdog expired");
        conclude();
    end
endmodule
